// ==== core/gcr_display.sv ====
// LED capacity display: level scaling, bank multiplexing, blink and pin control
`timescale 1ns/1ps
module gcr_display import gcr_pkg::*; #(
	parameter int PWM_CYC_P = PWM_CYC,
	parameter int BLINK_CYC_P = BLINK_CYC,
	parameter int HOLD_CYC_P = HOLD_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Display control pin sense, asynchronous
	input wire logic display_control_pin_low_pin,
	input wire logic display_control_pin_high_pin,
	// Capacity and status
	input wire logic [7:0] available_charge_count,
	input wire logic [7:0] learned_full_capacity,
	input wire logic [7:0] programmed_full_capacity,
	input wire logic absolute,
	input wire logic first_empty_warning,
	input wire logic chg_fast,
	input wire logic dis_fast,
	// Override
	input wire logic ovr_en,
	input wire logic [4:0] ovr_seg,
	// Pins
	output logic [4:0] led_segment_out,
	output logic led_common_out
);
	localparam int ON_CYC = PWM_CYC_P * BANK_ON_PCT / 100;
	localparam int HALF_CYC = PWM_CYC_P / 2;
	gcr_display_control_pin_st_s s, n;
	logic [7:0] ref_cap;
	logic [4:0] lvl;
	logic low_bat;
	logic active;
	logic bank_a, bank_b;

	assign ref_cap = absolute ? programmed_full_capacity : learned_full_capacity;
	genvar k;
	generate
		for (k = 0; k < 5; k++) begin : g_lvl
			// Segment k lights once charge exceeds k fifths of the reference
			assign lvl[k] = (12'(available_charge_count) * 12'(SEG_COUNT)) > (12'(ref_cap) * 12'(k));
		end
	endgenerate
	assign low_bat = first_empty_warning || ((12'(available_charge_count) * 12'(LOW_PCT_DIV)) < 12'(ref_cap));
	assign bank_a = s.pwm_cnt < 32'(ON_CYC);
	assign bank_b = (s.pwm_cnt >= 32'(HALF_CYC)) && (s.pwm_cnt < 32'(HALF_CYC + ON_CYC));

	always_comb begin
		n = s;
		n.lo_sync = {s.lo_sync[0], display_control_pin_low_pin};
		n.hi_sync = {s.hi_sync[0], display_control_pin_high_pin};
		n.pwm_cnt = (s.pwm_cnt == 32'(PWM_CYC_P - 1)) ? 32'h0 : s.pwm_cnt + 32'h1;
		n.blink_cnt = (s.blink_cnt == 32'(BLINK_CYC_P - 1)) ? 32'h0 : s.blink_cnt + 32'h1;
		if (s.blink_cnt == 32'(BLINK_CYC_P - 1)) begin
			n.blink = !s.blink;
		end
		// Held low keeps the display lit and re-arms the four second tail
		active = 1'b0;
		if (s.hi_sync[1]) begin
			n.hold_cnt = 32'h0;
		end else if (s.lo_sync[1]) begin
			n.hold_cnt = 32'(HOLD_CYC_P);
			active = 1'b1;
		end else if (s.hold_cnt != 32'h0) begin
			n.hold_cnt = s.hold_cnt - 32'h1;
			active = 1'b1;
		end else begin
			active = chg_fast || dis_fast;
		end
		if (ovr_en) begin
			n.seg = ovr_seg;
			n.com = 1'b1;
		end else begin
			n.seg = lvl;
			if (low_bat) begin
				n.seg[0] = s.blink;
			end
			n.seg = n.seg & ((bank_a ? BANK_A : 5'h00) | (bank_b ? BANK_B : 5'h00)) & {5{active}};
			n.com = active && (bank_a || bank_b);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign led_segment_out = s.seg;
	assign led_common_out = s.com;

	property p_ovr_drive;
		@(posedge mclk) disable iff (rst) ovr_en |=> led_segment_out == $past(ovr_seg);
	endproperty
	a_ovr_drive: assert property (p_ovr_drive) else $error("override bits not on segments");

	property p_dark;
		@(posedge mclk) disable iff (rst) (s.hi_sync[1] && !ovr_en) |=> led_segment_out == 5'h00;
	endproperty
	a_dark: assert property (p_dark) else $error("segments lit with display pin high");

	property p_banks;
		@(posedge mclk) disable iff (rst) !$past(ovr_en) |-> !(|(led_segment_out & BANK_A) && |(led_segment_out & BANK_B));
	endproperty
	a_banks: assert property (p_banks) else $error("both segment banks lit together");
endmodule // gcr_display

// ==== core/gcr_pkg.sv ====
// Shared constants and carrier types for the gauge register bank and display
package gcr_pkg;
	// Clock and timing
	localparam int CLK_HZ = 25_000_000;
	localparam int VSB_PERIOD_MS = 1000;
	localparam int HOLD_MS = 4000;
	localparam int PWM_HZ = 320;
	localparam int BLINK_HZ = 4;
	localparam int BANK_ON_PCT = 30;
	localparam int SEC_CYC = CLK_HZ / 1000 * VSB_PERIOD_MS;
	localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
	localparam int PWM_CYC = CLK_HZ / PWM_HZ;
	localparam int BLINK_CYC = CLK_HZ / (2 * BLINK_HZ);
	// Register addresses
	localparam logic [6:0] A_LMD = 7'h05;
	localparam logic [6:0] A_PULLDOWN = 7'h07;
	localparam logic [6:0] A_PULLUP = 7'h08;
	localparam logic [6:0] A_STRAP_RST = 7'h09;
	localparam logic [6:0] A_OVERRIDE = 7'h0a;
	localparam logic [6:0] A_OFFSET = 7'h0b;
	localparam logic [6:0] A_SDR = 7'h0c;
	localparam logic [6:0] A_DMF = 7'h0d;
	localparam logic [6:0] A_LIGHT_LOAD_COMP = 7'h0e;
	localparam logic [6:0] A_CHARGE_EFFICIENCY_REG = 7'h0f;
	localparam logic [6:0] A_VSB = 7'h7e;
	// Override register fields
	localparam int OVR_EN_BIT = 1;
	localparam int OVR_SEG_LSB = 2;
	// Strap-selected and fixed reset values
	localparam logic [7:0] OFS_NONE = 8'h00;
	localparam logic [7:0] OFS_75UV = 8'h2e;
	localparam logic [7:0] OFS_150UV = 8'h17;
	localparam logic [7:0] SDR_64 = 8'heb;
	localparam logic [7:0] SDR_128 = 8'hd6;
	localparam logic [7:0] SDR_512 = 8'h58;
	localparam logic [7:0] CHARGE_EFFICIENCY_REG_LOW = 8'h50;
	localparam logic [7:0] CHARGE_EFFICIENCY_REG_FLOAT = 8'h5a;
	localparam logic [7:0] CHARGE_EFFICIENCY_REG_HIGH = 8'h5f;
	localparam logic [7:0] DMF_DEFAULT = 8'hb4;
	localparam logic [7:0] ZERO8 = 8'h00;
	// Efficiency derating in percent
	localparam logic [7:0] EFF_TEMP_STEP = 8'h05;
	localparam logic [7:0] EFF_TRICKLE_DROP = 8'h0f;
	// Display scaling, bank masks and strap bit positions
	localparam logic [3:0] SEG_COUNT = 4'h5;
	localparam logic [3:0] LOW_PCT_DIV = 4'ha;
	localparam logic [4:0] BANK_A = 5'h15;
	localparam logic [4:0] BANK_B = 5'h0a;
	localparam int STRAP_OFS = 5;
	localparam int STRAP_SDR = 2;
	localparam int STRAP_CC = 4;

	typedef enum logic [1:0] {
		SEQ_INIT = 2'b00,
		SEQ_RUN = 2'b01,
		SEQ_ARMED = 2'b10,
		SEQ_RESET = 2'b11
	} gcr_seq_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} gcr_req_s;

	typedef struct packed {
		logic [5:0] pd;
		logic [5:0] pu;
	} gcr_strap_s;

	typedef struct packed {
		logic [7:0] available_charge_count;
		logic [7:0] programmed_full_capacity;
		logic [7:0] vsb_sample;
		logic below_q;
		logic chg_fast;
		logic dis_fast;
		logic first_empty_warning;
		logic absolute;
		logic [2:0] temp_band;
		logic trickle;
	} gcr_gauge_s;

	typedef struct packed {
		logic nac_clear;
		logic vdq_clear;
		logic brp_set;
		logic extra_dis;
		logic [7:0] learned_full_capacity;
		logic [7:0] offset;
		logic [7:0] self_discharge_rate_reg;
		logic [7:0] magnitude_filter_reg;
		logic [7:0] eff;
	} gcr_ctrl_s;

	typedef struct packed {
		logic [1:0] lo_sync;
		logic [1:0] hi_sync;
		logic [31:0] pwm_cnt;
		logic [31:0] blink_cnt;
		logic blink;
		logic [31:0] hold_cnt;
		logic [4:0] seg;
		logic com;
	} gcr_display_control_pin_st_s;
endpackage

// ==== core/gcr_regs.sv ====
// Configuration and status register bank with LED capacity display
`timescale 1ns/1ps
module gcr_regs import gcr_pkg::*; #(
	parameter int SEC_CYC_P = SEC_CYC,
	parameter int HOLD_CYC_P = HOLD_CYC,
	parameter int PWM_CYC_P = PWM_CYC,
	parameter int BLINK_CYC_P = BLINK_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register access from the serial engine
	input wire gcr_req_s req,
	output logic [7:0] rdata,
	// Strap detection results
	input wire gcr_strap_s straps,
	input wire logic strap_valid,
	// Gauge core status
	input wire gcr_gauge_s gauge,
	// Display control pin sense
	input wire logic display_control_pin_low_pin,
	input wire logic display_control_pin_high_pin,
	// Controls to the gauge core
	output gcr_ctrl_s ctrl,
	// LED pins
	output logic [4:0] led_segment_out,
	output logic led_common_out
);
	typedef struct packed {
		gcr_seq_e seq;
		logic [5:0] pd;
		logic [5:0] pu;
		logic [7:0] learned_full_capacity;
		logic [7:0] ovr;
		logic [7:0] offset;
		logic [7:0] self_discharge_rate_reg;
		logic [7:0] magnitude_filter_reg;
		logic [7:0] light_load_comp;
		logic [7:0] charge_efficiency_reg;
		logic [7:0] battery_voltage_reg;
		logic [7:0] eff;
		logic [7:0] rdata;
		logic [31:0] sec_cnt;
		logic [7:0] lc_acc;
		logic extra_dis;
		logic nac_clear;
		logic vdq_clear;
		logic brp_set;
	} gcr_st_s;

	gcr_st_s s, n;
	logic tick;
	logic wr_ok;
	logic [8:0] lc_sum;
	logic [8:0] derate;
	logic strap_load;

	assign tick = s.sec_cnt == 32'(SEC_CYC_P - 1);
	assign wr_ok = req.wr && (s.seq == SEQ_RUN || s.seq == SEQ_ARMED);
	assign lc_sum = {1'b0, s.lc_acc} + {1'b0, s.light_load_comp};
	assign strap_load = s.seq == SEQ_INIT && strap_valid;

	// Three-state strap decode: pull-down, pull-up or floating
	function automatic logic [7:0] pick(input logic pd, input logic pu,
		input logic [7:0] v_lo, input logic [7:0] v_fl, input logic [7:0] v_hi);
		logic [7:0] v;
		v = v_fl;
		if (pd && !pu) begin
			v = v_lo;
		end else if (pu && !pd) begin
			v = v_hi;
		end
		return v;
	endfunction

	always_comb begin
		n = s;
		n.nac_clear = 1'b0;
		n.vdq_clear = 1'b0;
		n.brp_set = 1'b0;
		n.extra_dis = 1'b0;
		derate = 9'h0;

		n.sec_cnt = tick ? 32'h0 : s.sec_cnt + 32'h1;
		if (tick) begin
			n.battery_voltage_reg = gauge.vsb_sample;
		end

		// Load compensation: accumulate each second below the charge threshold,
		// the carry is one extra discharge count on top of self-discharge
		if (tick && gauge.below_q) begin
			n.lc_acc = lc_sum[7:0];
			n.extra_dis = lc_sum[8];
		end

		// Derived efficiency, saturating at zero
		if (s.pu[STRAP_CC] && !s.pd[STRAP_CC]) begin
			derate = 9'(gauge.temp_band) * 9'(EFF_TEMP_STEP);
			if (gauge.trickle) begin
				derate = derate + 9'(EFF_TRICKLE_DROP);
			end
		end
		n.eff = (9'(s.charge_efficiency_reg) > derate) ? 8'(9'(s.charge_efficiency_reg) - derate) : ZERO8;

		if (req.rd) begin
			unique case (req.addr)
				A_LMD: n.rdata = s.learned_full_capacity;
				A_PULLDOWN: n.rdata = {2'b00, s.pd};
				A_PULLUP: n.rdata = {2'b00, s.pu};
				A_STRAP_RST: n.rdata = {2'b00, s.pu | s.pd};
				A_OFFSET: n.rdata = s.offset;
				A_SDR: n.rdata = s.self_discharge_rate_reg;
				A_DMF: n.rdata = s.magnitude_filter_reg;
				A_LIGHT_LOAD_COMP: n.rdata = s.light_load_comp;
				A_CHARGE_EFFICIENCY_REG: n.rdata = s.charge_efficiency_reg;
				A_VSB: n.rdata = s.battery_voltage_reg;
				default: n.rdata = ZERO8;
			endcase
		end

		// Host writes; detection registers and voltage are read only
		if (wr_ok) begin
			unique case (req.addr)
				A_LMD: n.learned_full_capacity = req.wdata;
				A_OVERRIDE: n.ovr = req.wdata;
				A_OFFSET: n.offset = req.wdata;
				A_SDR: n.self_discharge_rate_reg = req.wdata;
				A_DMF: n.magnitude_filter_reg = req.wdata;
				A_LIGHT_LOAD_COMP: n.light_load_comp = req.wdata;
				A_CHARGE_EFFICIENCY_REG: n.charge_efficiency_reg = req.wdata;
				default: n.learned_full_capacity = n.learned_full_capacity;
			endcase
		end

		unique case (s.seq)
			SEQ_INIT: begin
				// Straps sampled once detection has settled after reset release
				if (strap_valid) begin
					n.pd = straps.pd;
					n.pu = straps.pu;
					n.offset = pick(straps.pd[STRAP_OFS], straps.pu[STRAP_OFS],
						OFS_150UV, OFS_NONE, OFS_75UV);
					n.self_discharge_rate_reg = pick(straps.pd[STRAP_SDR], straps.pu[STRAP_SDR],
						SDR_512, SDR_128, SDR_64);
					n.charge_efficiency_reg = pick(straps.pd[STRAP_CC], straps.pu[STRAP_CC],
						CHARGE_EFFICIENCY_REG_LOW, CHARGE_EFFICIENCY_REG_FLOAT, CHARGE_EFFICIENCY_REG_HIGH);
					n.magnitude_filter_reg = DMF_DEFAULT;
					n.seq = SEQ_RESET;
				end
			end
			SEQ_RUN: begin
				if (req.wr && req.addr == A_STRAP_RST && req.wdata == ZERO8) begin
					n.seq = SEQ_ARMED;
				end
			end
			SEQ_ARMED: begin
				// Any other write between the pair disarms the software reset
				if (req.wr && req.addr == A_LMD && req.wdata == ZERO8) begin
					n.seq = SEQ_RESET;
				end else if (req.wr && !(req.addr == A_STRAP_RST && req.wdata == ZERO8)) begin
					n.seq = SEQ_RUN;
				end
			end
			SEQ_RESET: begin
				n.learned_full_capacity = gauge.programmed_full_capacity;
				n.ovr = ZERO8;
				n.light_load_comp = ZERO8;
				n.lc_acc = ZERO8;
				n.nac_clear = 1'b1;
				n.vdq_clear = 1'b1;
				n.brp_set = 1'b1;
				n.seq = SEQ_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign rdata = s.rdata;
	assign ctrl.nac_clear = s.nac_clear;
	assign ctrl.vdq_clear = s.vdq_clear;
	assign ctrl.brp_set = s.brp_set;
	assign ctrl.extra_dis = s.extra_dis;
	assign ctrl.learned_full_capacity = s.learned_full_capacity;
	assign ctrl.offset = s.offset;
	assign ctrl.self_discharge_rate_reg = s.self_discharge_rate_reg;
	assign ctrl.magnitude_filter_reg = s.magnitude_filter_reg;
	assign ctrl.eff = s.eff;

	gcr_display #(
		.PWM_CYC_P(PWM_CYC_P),
		.BLINK_CYC_P(BLINK_CYC_P),
		.HOLD_CYC_P(HOLD_CYC_P)
	) u_display (
		.mclk(mclk),
		.rst(rst),
		.display_control_pin_low_pin(display_control_pin_low_pin),
		.display_control_pin_high_pin(display_control_pin_high_pin),
		.available_charge_count(gauge.available_charge_count),
		.learned_full_capacity(s.learned_full_capacity),
		.programmed_full_capacity(gauge.programmed_full_capacity),
		.absolute(gauge.absolute),
		.first_empty_warning(gauge.first_empty_warning),
		.chg_fast(gauge.chg_fast),
		.dis_fast(gauge.dis_fast),
		.ovr_en(s.ovr[OVR_EN_BIT]),
		.ovr_seg(s.ovr[OVR_SEG_LSB +: 5]),
		.led_segment_out(led_segment_out),
		.led_common_out(led_common_out)
	);

	sequence s_arm;
		req.wr && req.addr == A_STRAP_RST && req.wdata == ZERO8 && (s.seq == SEQ_RUN || s.seq == SEQ_ARMED);
	endsequence

	// The second write may come any number of cycles later, so the armed state carries the pairing
	sequence s_fire;
		req.wr && req.addr == A_LMD && req.wdata == ZERO8 && s.seq == SEQ_ARMED;
	endsequence

	sequence s_pulse;
		s.seq == SEQ_RESET ##1 (ctrl.brp_set && ctrl.nac_clear && ctrl.vdq_clear);
	endsequence

	property p_arm;
		@(posedge mclk) disable iff (rst) s_arm |=> s.seq == SEQ_ARMED;
	endproperty
	a_arm: assert property (p_arm) else $error("strap reset write did not arm");

	property p_soft_reset;
		@(posedge mclk) disable iff (rst) s_fire |=> s_pulse;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("reset pair did not reset");

	property p_reset_state;
		@(posedge mclk) disable iff (rst)
			ctrl.brp_set |-> (s.light_load_comp == ZERO8 && !s.ovr[OVR_EN_BIT] && ctrl.learned_full_capacity == $past(gauge.programmed_full_capacity)
				&& ctrl.nac_clear && ctrl.vdq_clear);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset left state uncleared");

	property p_light_load_comp_zero;
		@(posedge mclk) disable iff (rst) ctrl.brp_set |-> s.light_load_comp == ZERO8 && s.lc_acc == ZERO8;
	endproperty
	a_light_load_comp_zero: assert property (p_light_load_comp_zero) else $error("load compensation not cleared");

	property p_rd_pulldown;
		@(posedge mclk) disable iff (rst) (req.rd && req.addr == A_PULLDOWN) |=> rdata == {2'b00, $past(s.pd)};
	endproperty
	a_rd_pulldown: assert property (p_rd_pulldown) else $error("pull-down read wrong");

	property p_rd_pullup;
		@(posedge mclk) disable iff (rst) (req.rd && req.addr == A_PULLUP) |=> rdata[7:6] == 2'b00 && rdata[5:0] == $past(s.pu);
	endproperty
	a_rd_pullup: assert property (p_rd_pullup) else $error("pull-up read wrong");

	property p_charge_efficiency_reg_wr;
		@(posedge mclk) disable iff (rst) (wr_ok && req.addr == A_CHARGE_EFFICIENCY_REG) |=> s.charge_efficiency_reg == $past(req.wdata);
	endproperty
	a_charge_efficiency_reg_wr: assert property (p_charge_efficiency_reg_wr) else $error("efficiency write lost");

	property p_vsb_tick;
		@(posedge mclk) disable iff (rst) $changed(s.battery_voltage_reg) |-> $past(tick);
	endproperty
	a_vsb_tick: assert property (p_vsb_tick) else $error("battery voltage changed off tick");

	property p_vsb_load;
		@(posedge mclk) disable iff (rst) tick |=> s.battery_voltage_reg == $past(gauge.vsb_sample);
	endproperty
	a_vsb_load: assert property (p_vsb_load) else $error("battery voltage not sampled on tick");

	property p_rd_vsb;
		@(posedge mclk) disable iff (rst) (req.rd && req.addr == A_VSB) |=> rdata == $past(s.battery_voltage_reg);
	endproperty
	a_rd_vsb: assert property (p_rd_vsb) else $error("battery voltage read wrong");

	property p_ovr_rd;
		@(posedge mclk) disable iff (rst) (req.rd && req.addr == A_OVERRIDE) |=> rdata == ZERO8;
	endproperty
	a_ovr_rd: assert property (p_ovr_rd) else $error("write-only override register read back");

	property p_wr_ignored;
		@(posedge mclk) disable iff (rst)
			(req.wr && (req.addr == A_PULLDOWN || req.addr == A_PULLUP) && s.seq == SEQ_RUN) |=> $stable(s.pd) && $stable(s.pu);
	endproperty
	a_wr_ignored: assert property (p_wr_ignored) else $error("detection register took a write");

	property p_strap_capture;
		@(posedge mclk) disable iff (rst)
			strap_load |=> s.pd == $past(straps.pd) && s.pu == $past(straps.pu);
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("strap detection not captured");

	property p_ofs_up;
		@(posedge mclk) disable iff (rst)
			(strap_load && straps.pu[STRAP_OFS] && !straps.pd[STRAP_OFS]) |=> ctrl.offset == OFS_75UV;
	endproperty
	a_ofs_up: assert property (p_ofs_up) else $error("pulled-up offset strap gave wrong value");

	property p_sdr_down;
		@(posedge mclk) disable iff (rst)
			(strap_load && straps.pd[STRAP_SDR] && !straps.pu[STRAP_SDR]) |=> ctrl.self_discharge_rate_reg == SDR_512;
	endproperty
	a_sdr_down: assert property (p_sdr_down) else $error("pulled-down rate strap gave wrong value");

	property p_cc_up;
		@(posedge mclk) disable iff (rst)
			(strap_load && straps.pu[STRAP_CC] && !straps.pd[STRAP_CC]) |=> s.charge_efficiency_reg == CHARGE_EFFICIENCY_REG_HIGH;
	endproperty
	a_cc_up: assert property (p_cc_up) else $error("pulled-up efficiency strap gave wrong value");

	property p_dmf_default;
		@(posedge mclk) disable iff (rst) strap_load |=> ctrl.magnitude_filter_reg == DMF_DEFAULT;
	endproperty
	a_dmf_default: assert property (p_dmf_default) else $error("filter default not loaded");

	property p_eff_plain;
		@(posedge mclk) disable iff (rst)
			(s.pd[STRAP_CC] || !s.pu[STRAP_CC]) |=> ctrl.eff == $past(s.charge_efficiency_reg);
	endproperty
	a_eff_plain: assert property (p_eff_plain) else $error("efficiency derated without pulled-up strap");

	property p_extra_dis;
		@(posedge mclk) disable iff (rst) ctrl.extra_dis |-> $past(tick) && $past(gauge.below_q);
	endproperty
	a_extra_dis: assert property (p_extra_dis) else $error("extra discharge off tick");

	property p_brp_pulse;
		@(posedge mclk) disable iff (rst) ctrl.brp_set |=> !ctrl.brp_set;
	endproperty
	a_brp_pulse: assert property (p_brp_pulse) else $error("reset indicator pulse too long");
endmodule // gcr_regs

// ==== verif/gcr_host_model.sv ====
// Host-side partner: issues register requests as the serial engine would
`timescale 1ns/1ps
module gcr_host_model import gcr_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register access
	output gcr_req_s req,
	input wire logic [7:0] rdata,
	// Read result
	output logic rvalid,
	output logic [7:0] rval
);
	initial req = '0;
	// Read data is taken one edge after the request edge
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
		end
	end
	assign rval = rdata;
	// One-cycle strobe; released fields show inverted data so stale values never pass
	task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(negedge mclk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge mclk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule // gcr_host_model

// ==== verif/test_gauge_config_regs_led_display.sv ====
// Self-checking bench: strap, register, compensation, reset and display checks
`timescale 1ns/1ps
module test_gauge_config_regs_led_display import gcr_pkg::*;;
	logic mclk;
	logic rst;
	logic strap_valid;
	logic display_control_pin_low_pin;
	logic display_control_pin_high_pin;
	logic rvalid;
	logic [7:0] rdata;
	logic [7:0] rval;
	logic [7:0] v;
	logic [7:0] e;
	logic [4:0] s;
	logic [4:0] seg_or;
	logic [4:0] led_segment_out;
	logic led_common_out;
	gcr_req_s req;
	gcr_strap_s straps;
	gcr_gauge_s gauge;
	gcr_ctrl_s ctrl;
	logic [7:0] exp_q[$];
	int miscompares;
	int n_compared;
	int cnt_a, cnt_b, cnt_mx, cnt_bl, n_xd, n_rp, n_com;

	// Short counts keep the run brief
	gcr_regs #(.SEC_CYC_P(20), .HOLD_CYC_P(50), .PWM_CYC_P(20), .BLINK_CYC_P(16)) gcr_regs_i (
		.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .straps(straps), .strap_valid(strap_valid),
		.gauge(gauge), .display_control_pin_low_pin(display_control_pin_low_pin), .display_control_pin_high_pin(display_control_pin_high_pin), .ctrl(ctrl),
		.led_segment_out(led_segment_out), .led_common_out(led_common_out));
	gcr_host_model gcr_host_model_i (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
		.rvalid(rvalid), .rval(rval));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input string what, input logic [7:0] ex, input logic [7:0] got);
		n_compared++;
		if (got !== ex) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, ex, got);
		end
	endtask

	task automatic stop_test();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		gcr_host_model_i.access(1'b1, a, d);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] ex);
		exp_q.push_back(ex);
		gcr_host_model_i.access(1'b0, a, 8'h00);
	endtask

	// Oldest noted read value is matched against each returned result
	always @(negedge mclk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) chk("unexpected read", 8'h00, 8'hff);
			else chk("rdata", exp_q.pop_front(), rval);
		end
	end

	task automatic watch(input int n);
		seg_or = 5'h00;
		{cnt_a, cnt_b, cnt_mx, cnt_bl, n_xd, n_rp, n_com} = '0;
		repeat (n) begin
			@(negedge mclk);
			seg_or = seg_or | led_segment_out;
			cnt_a += int'((led_segment_out & BANK_A) != 5'h00);
			cnt_b += int'((led_segment_out & BANK_B) != 5'h00);
			cnt_mx += int'((led_segment_out & BANK_A) != 5'h00 && (led_segment_out & BANK_B) != 5'h00);
			cnt_bl += int'(led_segment_out[2] && !led_segment_out[0]);
			n_xd += int'(ctrl.extra_dis);
			n_rp += int'(ctrl.brp_set && ctrl.nac_clear && ctrl.vdq_clear);
			n_com += int'(led_common_out);
		end
	endtask

	// Straps 2, 4 and 5 forced to one state (0 down, 1 float, 2 up), others random
	task automatic do_reset(input int k);
		v = 8'($urandom);
		straps.pd = (v[5:0] & 6'h0b) | (k == 0 ? 6'h34 : 6'h00);
		straps.pu = (~v[5:0] & 6'h03) | (k == 2 ? 6'h34 : 6'h00);
		rst = 1'b1;
		strap_valid = 1'b0;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		strap_valid = 1'b1;
		repeat (6) @(negedge mclk);
	endtask

	initial begin
		repeat (6000) @(posedge mclk);
		miscompares++;
		stop_test();
	end

	initial begin
		rst = 1'b1;
		strap_valid = 1'b0;
		display_control_pin_low_pin = 1'b0;
		display_control_pin_high_pin = 1'b1;
		straps = '0;
		gauge = '0;
		miscompares = 0;
		n_compared = 0;
		gauge.programmed_full_capacity = 8'd100;
		gauge.available_charge_count = 8'd100;
		gauge.temp_band = 3'd2;
		gauge.trickle = 1'b1;
		void'($urandom(32'hf5ab));
		for (int k = 0; k < 3; k++) begin
			do_reset(k);
			rd(A_PULLDOWN, {2'b00, straps.pd});
			rd(A_PULLUP, {2'b00, straps.pu});
			rd(A_OFFSET, k == 2 ? OFS_75UV : k == 1 ? OFS_NONE : OFS_150UV);
			rd(A_SDR, k == 2 ? SDR_64 : k == 1 ? SDR_128 : SDR_512);
			e = k == 2 ? CHARGE_EFFICIENCY_REG_HIGH : k == 1 ? CHARGE_EFFICIENCY_REG_FLOAT : CHARGE_EFFICIENCY_REG_LOW;
			rd(A_CHARGE_EFFICIENCY_REG, e);
			rd(A_DMF, DMF_DEFAULT);
			rd(A_LIGHT_LOAD_COMP, ZERO8);
			chk("offset out", k == 2 ? OFS_75UV : k == 1 ? OFS_NONE : OFS_150UV, ctrl.offset);
			chk("rate out", k == 2 ? SDR_64 : k == 1 ? SDR_128 : SDR_512, ctrl.self_discharge_rate_reg);
			chk("filter out", DMF_DEFAULT, ctrl.magnitude_filter_reg);
			chk("lmd", gauge.programmed_full_capacity, ctrl.learned_full_capacity);
			chk("eff", 8'(k == 2 ? e - 2 * EFF_TEMP_STEP - EFF_TRICKLE_DROP : e), ctrl.eff);
			$display("strap setting %0d done", k);
		end
		wr(A_PULLDOWN, 8'hff);
		rd(A_PULLDOWN, {2'b00, straps.pd});
		v = 8'($urandom);
		wr(A_CHARGE_EFFICIENCY_REG, v);
		rd(A_CHARGE_EFFICIENCY_REG, v);
		wr(A_DMF, ~v);
		rd(A_DMF, ~v);
		rd(A_OVERRIDE, ZERO8);
		rd(7'h30, ZERO8);
		gauge.vsb_sample = v;
		repeat (45) @(negedge mclk);
		rd(A_VSB, v);
		gauge.below_q = 1'b1;
		wr(A_LIGHT_LOAD_COMP, 8'h80);
		watch(80);
		chk("extra discharge", 8'd2, 8'(n_xd));
		gauge.below_q = 1'b0;
		watch(80);
		chk("idle discharge", 8'd0, 8'(n_xd));
		$display("register test done");
		s = 5'($urandom) | 5'h01;
		wr(A_OVERRIDE, {1'b1, s, 2'b10});
		watch(20);
		chk("override", s, led_segment_out);
		chk("override held", s, seg_or);
		chk("common override", 8'd20, 8'(n_com));
		wr(A_OVERRIDE, 8'h00);
		repeat (4) @(negedge mclk);
		watch(40);
		chk("override off", 8'h00, seg_or);
		wr(A_OVERRIDE, {1'b1, s, 2'b10});
		wr(A_LMD, 8'd50);
		chk("lmd written", 8'd50, ctrl.learned_full_capacity);
		wr(A_STRAP_RST, 8'h00);
		wr(A_LMD, 8'h00);
		watch(6);
		chk("reset pulses", 8'd1, 8'(n_rp));
		chk("lmd reload", gauge.programmed_full_capacity, ctrl.learned_full_capacity);
		rd(A_LIGHT_LOAD_COMP, ZERO8);
		watch(20);
		chk("override cleared", 8'h00, seg_or);
		$display("override and reset test done");
		display_control_pin_high_pin = 1'b0;
		display_control_pin_low_pin = 1'b1;
		repeat (4) @(negedge mclk);
		watch(40);
		chk("all lit", 8'h1f, seg_or);
		chk("bank a share", 8'd12, 8'(cnt_a));
		chk("bank b share", 8'd12, 8'(cnt_b));
		chk("bank overlap", 8'd0, 8'(cnt_mx));
		chk("common share", 8'd24, 8'(n_com));
		wr(A_LMD, 8'd50);
		gauge.available_charge_count = 8'd30;
		watch(40);
		chk("relative level", 8'h07, seg_or);
		gauge.absolute = 1'b1;
		repeat (2) @(negedge mclk);
		watch(40);
		chk("absolute level", 8'h03, seg_or);
		gauge.absolute = 1'b0;
		gauge.available_charge_count = 8'd50;
		gauge.first_empty_warning = 1'b1;
		watch(64);
		chk("blink", 8'd1, 8'(cnt_bl > 0));
		gauge.first_empty_warning = 1'b0;
		repeat (2) @(negedge mclk);
		watch(64);
		chk("steady", 8'd0, 8'(cnt_bl));
		display_control_pin_low_pin = 1'b0;
		watch(40);
		chk("hold after release", 8'h1f, seg_or);
		repeat (30) @(negedge mclk);
		watch(40);
		chk("float idle", 8'h00, seg_or);
		gauge.chg_fast = 1'b1;
		watch(40);
		chk("fast charge lit", 8'h1f, seg_or);
		gauge.chg_fast = 1'b0;
		gauge.dis_fast = 1'b1;
		watch(40);
		chk("fast discharge lit", 8'h1f, seg_or);
		display_control_pin_high_pin = 1'b1;
		repeat (4) @(negedge mclk);
		watch(40);
		chk("pin high blank", 8'h00, seg_or);
		chk("common blank", 8'd0, 8'(n_com));
		$display("display test done");
		repeat (3) @(negedge mclk);
		chk("pending reads", 8'h00, 8'(exp_q.size()));
		stop_test();
	end
endmodule // test_gauge_config_regs_led_display
